// ### link_alarm_pkg.sv
/*
  constants shared by the link control / alarm block and its host end.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package link_alarm_pkg;
  // ****************
  // widths
  // ****************
  localparam int NUM_LANES = 16;
  localparam int EMPH_W = 5;
  localparam int ALARM_W = 6;
  localparam int CNT_W = 5;
  // ****************
  // alarm flag positions
  // ****************
  localparam int ALM_FIFO = 0;
  localparam int ALM_PLL = 1;
  localparam int ALM_LINK_IDLE = 2;
  localparam int ALM_REALIGN = 3;
  localparam int ALM_NCO = 4;
  localparam int ALM_CLK = 5;
  // ****************
  // reset values and counts
  // ****************
  localparam logic [ALARM_W-1:0] ALARM_RST = 6'h00;
  localparam logic [NUM_LANES-1:0] LANE_RST = 16'h0000;
  localparam logic [EMPH_W-1:0] EMPH_RST = 5'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  // clock compare runs at device_sample_clock / 2
  localparam int CLK_CMP_DIV = 2;
  // cycles the link block is held in reset after a buffer-fault reinit
  localparam logic [3:0] REINIT_CYCLES = 4'h8;
  // default counter period in frame clocks, minus one
  localparam logic [CNT_W-1:0] PERIOD_M1_RST = 5'h1f;
  // link states
  typedef enum logic [3:0] {
    LS_OFF = 4'b0001,
    LS_SYNC = 4'b0010,
    LS_ALIGN = 4'b0100,
    LS_DATA = 4'b1000
  } link_state_e;
endpackage
`default_nettype wire

// ### link_alarm_if.sv
/*
  carrier between the link block (device end) and its host end.
  assumes both ends run on the same i_mclk.
*/
`timescale 1ns/10ps
`default_nettype none
interface link_alarm_if;
  // configuration from host
  logic link_enable;
  logic [link_alarm_pkg::EMPH_W-1:0] serializer_emphasis_level;
  logic use_64b66b;
  logic subclass1;
  logic reinit_on_buffer_fault;
  logic [link_alarm_pkg::ALARM_W-1:0] alarm_mask;
  logic cal_pin_sel_alarm;
  logic input_swap;
  logic [link_alarm_pkg::CNT_W-1:0] period_m1;
  // write-one-to-clear strobes
  logic clear_valid;
  logic [link_alarm_pkg::ALARM_W-1:0] clear_flags;
  logic [link_alarm_pkg::NUM_LANES-1:0] clear_lanes;
  // status to host
  logic [link_alarm_pkg::ALARM_W-1:0] alarm_flags;
  logic [link_alarm_pkg::NUM_LANES-1:0] per_lane_buffer_fault_flags;
  logic alarm_summary;
  logic calibration_status_pin;
  logic in_data_state;
  modport device (
    input link_enable, serializer_emphasis_level, use_64b66b, subclass1,
    input reinit_on_buffer_fault, alarm_mask, cal_pin_sel_alarm, input_swap, period_m1,
    input clear_valid, clear_flags, clear_lanes,
    output alarm_flags, per_lane_buffer_fault_flags, alarm_summary,
    output calibration_status_pin, in_data_state
  );
  modport host (
    output link_enable, serializer_emphasis_level, use_64b66b, subclass1,
    output reinit_on_buffer_fault, alarm_mask, cal_pin_sel_alarm, input_swap, period_m1,
    output clear_valid, clear_flags, clear_lanes,
    input alarm_flags, per_lane_buffer_fault_flags, alarm_summary,
    input calibration_status_pin, in_data_state
  );
endinterface
`default_nettype wire

// ### pin_sync2.sv
/*
  two-flop synchroniser for a bus of independent levels.
  assumes each bit is a slow level; no word coherence is promised.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meta_reg <= '0;
      o_sync <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### link_enable_alarm_monitor.sv
/*
  device end: link enable / reset gating, emphasis, timing-reference
  counter, sticky alarm collector with mask, summary and status pin.
  assumes pins from other domains (timing reference, sync request, clock
  compare, pll lock, upset strobes) are resynchronised here; lane fault
  pulses come from logic on i_mclk.
*/
// Summary of operation
// - link enable low holds link, serializers, clocks off
// - host disables link before changing link setup
// - link enable high releases link with setup
// - multi-bit emphasis level, larger is stronger
// - timing reference resets multiframe or multiblock counter
// - receiver offsets release point away from arrival spread
// - receiver releases once all lanes arrive
// - subclass 0 counter free-runs with arbitrary phase
// - subclass 0 8b/10b still answers sync request
// - six separate sticky alarm sources
// - alarm bit stays set until host writes one
// - summary alarm only from unmasked set bits
// - status pin high on alarm when selected
// - channel clock mismatch sets clock alarm
// - host enables link, powers channels, clears clock alarm
// - host clears clock alarm after power-down exit
// - lane fifo over or underflow sets fifo alarm
// - per-lane fifo flag names the offending lane
// - optional auto reinit on fifo alarm
// - dual-channel input swap exchanges channel inputs
`timescale 1ns/10ps
`default_nettype none
module link_enable_alarm_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // host side
  link_alarm_if.device bus,
  // pins from other domains
  input wire logic i_timing_ref,
  input wire logic i_sync_req_n,
  input wire logic i_clk_a_phase,
  input wire logic i_clk_b_phase,
  input wire logic i_channel_a_power_down,
  input wire logic i_channel_b_power_down,
  input wire logic i_pll_locked,
  input wire logic i_nco_upset,
  // lane fault pulses, same domain
  input wire logic [link_alarm_pkg::NUM_LANES-1:0] i_lane_overflow,
  input wire logic [link_alarm_pkg::NUM_LANES-1:0] i_lane_underflow,
  // analog front controls
  input wire logic i_dual_channel,
  // link controls
  output logic o_link_reset,
  output logic o_serializer_power_down,
  output logic o_link_clock_gate_en,
  output logic [link_alarm_pkg::EMPH_W-1:0] o_serializer_emphasis_level,
  output logic o_frame_counter_edge,
  output logic o_start_sync,
  output logic o_start_align,
  output logic o_channel_a_from_input_b,
  output logic o_channel_b_from_input_a
);
  // ****************
  // synchronisers
  // ****************
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  assign raw_in = {i_timing_ref, i_sync_req_n, i_clk_a_phase, i_clk_b_phase,
                   i_channel_a_power_down, i_channel_b_power_down,
                   i_pll_locked, i_nco_upset};
  pin_sync2 #(.W(NSYNC)) pin_sync2_inst (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_async(raw_in),
    .o_sync(syn)
  );
  logic tref_s, sync_n_s, clk_a_s, clk_b_s, pd_a_s, pd_b_s, pll_s, nco_s;
  assign {tref_s, sync_n_s, clk_a_s, clk_b_s, pd_a_s, pd_b_s, pll_s, nco_s} = syn;

  // w1c update: event set wins over clear
  function automatic logic [link_alarm_pkg::NUM_LANES-1:0] sticky(
    input logic [link_alarm_pkg::NUM_LANES-1:0] cur,
    input logic [link_alarm_pkg::NUM_LANES-1:0] set,
    input logic [link_alarm_pkg::NUM_LANES-1:0] clr
  );
    sticky = (cur & ~clr) | set;
  endfunction

  // ****************
  // enable and reinit gating
  // ****************
  logic tref_d_reg, nco_d_reg, tref_edge, fifo_event;
  logic [3:0] reinit_cnt_reg;
  logic link_run;
  assign tref_edge = tref_s & ~tref_d_reg;
  assign fifo_event = |(i_lane_overflow | i_lane_underflow);
  // reinit counts down holding link reset
  always_ff @(posedge i_mclk) begin
    if (i_srst || !bus.link_enable) begin
      reinit_cnt_reg <= 4'h0;
    end else if (fifo_event && bus.reinit_on_buffer_fault && link_run) begin
      reinit_cnt_reg <= link_alarm_pkg::REINIT_CYCLES;
    end else if (reinit_cnt_reg != 4'h0) begin
      reinit_cnt_reg <= reinit_cnt_reg - 4'h1;
    end
  end
  assign link_run = bus.link_enable && (reinit_cnt_reg == 4'h0);
  // control outputs registered so gating is glitch free
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_link_reset <= 1'b1;
      o_serializer_power_down <= 1'b1;
      o_link_clock_gate_en <= 1'b0;
      o_serializer_emphasis_level <= link_alarm_pkg::EMPH_RST;
    end else begin
      o_link_reset <= !link_run;
      o_serializer_power_down <= !link_run;
      o_link_clock_gate_en <= link_run;
      o_serializer_emphasis_level <= bus.serializer_emphasis_level;
    end
  end

  // ****************
  // frame counter
  // ****************
  logic [link_alarm_pkg::CNT_W-1:0] fcnt_reg;
  // subclass 1 resyncs on reference; subclass 0 just free-runs
  always_ff @(posedge i_mclk) begin
    if (i_srst || !link_run) begin
      fcnt_reg <= link_alarm_pkg::CNT_RST;
      o_frame_counter_edge <= 1'b0;
    end else if (bus.subclass1 && tref_edge) begin
      fcnt_reg <= link_alarm_pkg::CNT_RST;
      o_frame_counter_edge <= 1'b1;
    end else if (fcnt_reg >= bus.period_m1) begin
      fcnt_reg <= link_alarm_pkg::CNT_RST;
      o_frame_counter_edge <= 1'b1;
    end else begin
      fcnt_reg <= fcnt_reg + 5'h01;
      o_frame_counter_edge <= 1'b0;
    end
  end

  // ****************
  // link state machine
  // ****************
  link_alarm_pkg::link_state_e st_reg;
  // 8b/10b waits for sync request release; 64b/66b goes straight to data
  always_ff @(posedge i_mclk) begin
    if (i_srst || !link_run) begin
      st_reg <= link_alarm_pkg::LS_OFF;
    end else begin
      case (st_reg)
        link_alarm_pkg::LS_OFF: begin
          st_reg <= bus.use_64b66b ? link_alarm_pkg::LS_DATA : link_alarm_pkg::LS_SYNC;
        end
        link_alarm_pkg::LS_SYNC: begin
          if (!sync_n_s) st_reg <= link_alarm_pkg::LS_SYNC;
          else st_reg <= link_alarm_pkg::LS_ALIGN;
        end
        link_alarm_pkg::LS_ALIGN: begin
          if (!sync_n_s) st_reg <= link_alarm_pkg::LS_SYNC;
          else if (o_frame_counter_edge) st_reg <= link_alarm_pkg::LS_DATA;
        end
        link_alarm_pkg::LS_DATA: begin
          if (!bus.use_64b66b && !sync_n_s) st_reg <= link_alarm_pkg::LS_SYNC;
        end
        default: st_reg <= link_alarm_pkg::LS_OFF;
      endcase
    end
  end
  assign o_start_sync = (st_reg == link_alarm_pkg::LS_SYNC);
  assign o_start_align = (st_reg == link_alarm_pkg::LS_ALIGN);
  assign bus.in_data_state = (st_reg == link_alarm_pkg::LS_DATA);

  // ****************
  // clock compare at half rate
  // ****************
  logic half_reg, clk_mismatch;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      half_reg <= 1'b0;
      tref_d_reg <= 1'b0;
      nco_d_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      tref_d_reg <= tref_s;
      nco_d_reg <= nco_s;
    end
  end
  // only meaningful with both channels up
  assign clk_mismatch = half_reg && !pd_a_s && !pd_b_s && (clk_a_s != clk_b_s);

  // ****************
  // alarm collector
  // ****************
  logic [link_alarm_pkg::ALARM_W-1:0] alarm_set;
  logic [link_alarm_pkg::ALARM_W-1:0] clr6;
  logic [link_alarm_pkg::NUM_LANES-1:0] clr_l;
  logic [link_alarm_pkg::NUM_LANES-1:0] alm_w, alm_next;
  logic [link_alarm_pkg::NUM_LANES-1:0] lane_reg;
  logic [link_alarm_pkg::ALARM_W-1:0] alarm_reg;
  always_comb begin
    alarm_set = link_alarm_pkg::ALARM_RST;
    alarm_set[link_alarm_pkg::ALM_FIFO] = fifo_event;
    alarm_set[link_alarm_pkg::ALM_PLL] = link_run && !pll_s;
    alarm_set[link_alarm_pkg::ALM_LINK_IDLE] = bus.link_enable && !bus.in_data_state;
    alarm_set[link_alarm_pkg::ALM_REALIGN] = bus.subclass1 && tref_edge && link_run
                                             && (fcnt_reg != link_alarm_pkg::CNT_RST);
    alarm_set[link_alarm_pkg::ALM_NCO] = nco_s && !nco_d_reg;
    alarm_set[link_alarm_pkg::ALM_CLK] = clk_mismatch;
  end
  assign clr6 = bus.clear_valid ? bus.clear_flags : link_alarm_pkg::ALARM_RST;
  assign clr_l = bus.clear_valid ? bus.clear_lanes : link_alarm_pkg::LANE_RST;
  assign alm_w = {10'h000, alarm_reg};
  assign alm_next = sticky(alm_w, {10'h000, alarm_set}, {10'h000, clr6});
  // sticky flags, one per source
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      alarm_reg <= link_alarm_pkg::ALARM_RST;
      lane_reg <= link_alarm_pkg::LANE_RST;
    end else begin
      alarm_reg <= alm_next[link_alarm_pkg::ALARM_W-1:0];
      lane_reg <= sticky(lane_reg, i_lane_overflow | i_lane_underflow, clr_l);
    end
  end
  assign bus.alarm_flags = alarm_reg;
  assign bus.per_lane_buffer_fault_flags = lane_reg;
  // summary and pin registered for clean pin level
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bus.alarm_summary <= 1'b0;
      bus.calibration_status_pin <= 1'b0;
    end else begin
      bus.alarm_summary <= |(alarm_reg & ~bus.alarm_mask);
      bus.calibration_status_pin <= bus.cal_pin_sel_alarm
                                    && |(alarm_reg & ~bus.alarm_mask);
    end
  end

  // ****************
  // input routing
  // ****************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_channel_a_from_input_b <= 1'b0;
      o_channel_b_from_input_a <= 1'b0;
    end else begin
      o_channel_a_from_input_b <= i_dual_channel && bus.input_swap;
      o_channel_b_from_input_a <= i_dual_channel && bus.input_swap;
    end
  end
endmodule
`default_nettype wire

// ### link_alarm_host.sv
/*
  host end: holds link setup, sequences enable around changes and
  registers user clear requests as clear strobes one cycle later, held as long as i_clear.
  assumes user requests come from logic on i_mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module link_alarm_host (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // device side
  link_alarm_if.host bus,
  // user setup, taken on i_cfg_load
  input wire logic i_cfg_load,
  input wire logic i_enable,
  input wire logic [link_alarm_pkg::EMPH_W-1:0] i_emphasis,
  input wire logic i_use_64b66b,
  input wire logic i_subclass1,
  input wire logic i_reinit_on_fault,
  input wire logic [link_alarm_pkg::ALARM_W-1:0] i_alarm_mask,
  input wire logic i_cal_pin_alarm,
  input wire logic i_input_swap,
  input wire logic [link_alarm_pkg::CNT_W-1:0] i_period_m1,
  // user clear request
  input wire logic i_clear,
  input wire logic [link_alarm_pkg::ALARM_W-1:0] i_clear_flags,
  input wire logic [link_alarm_pkg::NUM_LANES-1:0] i_clear_lanes,
  // status
  output logic o_busy,
  output logic [link_alarm_pkg::ALARM_W-1:0] o_alarm_flags,
  output logic o_alarm
);
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_LOAD = 3'b010,
    PH_APPLY = 3'b100
  } host_phase_e;
  host_phase_e phase_reg;
  // link goes off before setup moves, and comes back only once setup is final
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      phase_reg <= PH_IDLE;
      bus.link_enable <= 1'b0;
      bus.serializer_emphasis_level <= link_alarm_pkg::EMPH_RST;
      bus.use_64b66b <= 1'b0;
      bus.subclass1 <= 1'b0;
      bus.reinit_on_buffer_fault <= 1'b0;
      bus.alarm_mask <= link_alarm_pkg::ALARM_RST;
      bus.cal_pin_sel_alarm <= 1'b0;
      bus.input_swap <= 1'b0;
      bus.period_m1 <= link_alarm_pkg::PERIOD_M1_RST;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (i_cfg_load) begin
            bus.link_enable <= 1'b0;
            phase_reg <= PH_LOAD;
          end
        end
        PH_LOAD: begin
          bus.serializer_emphasis_level <= i_emphasis;
          bus.use_64b66b <= i_use_64b66b;
          bus.subclass1 <= i_subclass1;
          bus.reinit_on_buffer_fault <= i_reinit_on_fault;
          bus.alarm_mask <= i_alarm_mask;
          bus.cal_pin_sel_alarm <= i_cal_pin_alarm;
          bus.input_swap <= i_input_swap;
          bus.period_m1 <= i_period_m1;
          phase_reg <= PH_APPLY;
        end
        PH_APPLY: begin
          bus.link_enable <= i_enable;
          phase_reg <= PH_IDLE;
        end
        default: begin
          phase_reg <= PH_IDLE;
        end
      endcase
    end
  end
  assign o_busy = (phase_reg != PH_IDLE);
  // write-one-to-clear strobe, i_clear registered one cycle late
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bus.clear_valid <= 1'b0;
      bus.clear_flags <= link_alarm_pkg::ALARM_RST;
      bus.clear_lanes <= link_alarm_pkg::LANE_RST;
    end else begin
      bus.clear_valid <= i_clear;
      bus.clear_flags <= i_clear_flags;
      bus.clear_lanes <= i_clear_lanes;
    end
  end
  assign o_alarm_flags = bus.alarm_flags;
  assign o_alarm = bus.alarm_summary;
endmodule
`default_nettype wire

// ### link_alarm_chk.sv
/*
  checker beside the carrier: sticky flags, summary, pin, link gating.
  assumes both ends run on i_mclk with i_srst synchronous, active high.
*/
`timescale 1ns/10ps
`default_nettype none
module link_alarm_chk (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // carrier signals
  input wire logic link_enable,
  input wire logic use_64b66b,
  input wire logic reinit_on_buffer_fault,
  input wire logic cal_pin_sel_alarm,
  input wire logic [link_alarm_pkg::EMPH_W-1:0] serializer_emphasis_level,
  input wire logic [link_alarm_pkg::ALARM_W-1:0] alarm_mask,
  input wire logic clear_valid,
  input wire logic [link_alarm_pkg::ALARM_W-1:0] clear_flags,
  input wire logic [link_alarm_pkg::NUM_LANES-1:0] clear_lanes,
  input wire logic [link_alarm_pkg::ALARM_W-1:0] alarm_flags,
  input wire logic [link_alarm_pkg::NUM_LANES-1:0] per_lane_buffer_fault_flags,
  input wire logic alarm_summary,
  input wire logic calibration_status_pin,
  input wire logic in_data_state
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // ****************
  // flags
  // ****************
  // only a clear strobe may drop a flag
  AST_STICKY: assert property (($past(alarm_flags) & ~alarm_flags
    & ~($past(clear_valid) ? $past(clear_flags) : '0)) == '0) else $error("flag lost");
  AST_LANE_STICKY: assert property (($past(per_lane_buffer_fault_flags)
    & ~per_lane_buffer_fault_flags
    & ~($past(clear_valid) ? $past(clear_lanes) : '0)) == '0) else $error("lane lost");
  AST_LANE_FIFO: assert property (|(per_lane_buffer_fault_flags
    & ~$past(per_lane_buffer_fault_flags)) |-> ##[0:1] alarm_flags[link_alarm_pkg::ALM_FIFO])
    else $error("fifo flag missing");
  AST_RESET: assert property ($past(i_srst) |-> alarm_flags == '0
    && per_lane_buffer_fault_flags == '0) else $error("flags not zero");
  AST_SUMMARY: assert property (alarm_summary ==
    |($past(alarm_flags) & ~$past(alarm_mask))) else $error("summary wrong");
  // pin follows an unmasked alarm one cycle on
  AST_PIN: assert property (cal_pin_sel_alarm && |(alarm_flags & ~alarm_mask)
    |=> calibration_status_pin) else $error("pin low");
  AST_IDLE: assert property ((link_enable && !reinit_on_buffer_fault
    && !in_data_state) [*4] |-> alarm_flags[link_alarm_pkg::ALM_LINK_IDLE])
    else $error("idle flag missing");
  // ****************
  // link gating
  // ****************
  AST_OFF: assert property ((!link_enable) [*3] |-> !in_data_state)
    else $error("data while disabled");
  AST_DATA64: assert property ((link_enable && use_64b66b
    && !reinit_on_buffer_fault) [*4] |-> in_data_state) else $error("no data state");
  AST_HOST_SEQ: assert property ($changed(serializer_emphasis_level)
    |-> !link_enable && !$past(link_enable)) else $error("setup changed live");
  C_SUM: cover property ($rose(alarm_summary));
  C_DATA: cover property ($rose(in_data_state));
  C_CLR: cover property (clear_valid && (clear_flags & alarm_flags) != '0);
endmodule
`default_nettype wire

// ### link_enable_alarm_monitor_test.sv
/*
  bench: host end and device end joined by the carrier, with checker.
  assumes one 100 MHz clock for both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module link_enable_alarm_monitor_test;
  logic i_mclk, i_srst, i_cfg_load, i_enable, i_use_64b66b, i_subclass1, i_clear;
  logic i_reinit_on_fault, i_cal_pin_alarm, i_input_swap, i_dual_channel, i_nco_upset;
  logic i_timing_ref, i_sync_req_n, i_clk_a_phase, i_clk_b_phase, i_pll_locked;
  logic i_channel_a_power_down, i_channel_b_power_down, o_busy, o_alarm, o_link_reset;
  logic o_serializer_power_down, o_link_clock_gate_en, o_frame_counter_edge;
  logic o_start_sync, o_start_align, o_channel_a_from_input_b, o_channel_b_from_input_a;
  logic [4:0] i_emphasis, i_period_m1, o_serializer_emphasis_level;
  logic [5:0] i_alarm_mask, i_clear_flags, o_alarm_flags;
  logic [15:0] i_clear_lanes, i_lane_overflow, i_lane_underflow, oh;
  logic [31:0] seed;
  int n_mismatch, samples_checked, cyc, t, n;
  link_alarm_if bus();
  link_alarm_host link_alarm_host_inst (.*);
  link_enable_alarm_monitor link_enable_alarm_monitor_inst (.*);
  link_alarm_chk link_alarm_chk_inst (.i_mclk(i_mclk), .i_srst(i_srst),
    .link_enable(bus.link_enable), .use_64b66b(bus.use_64b66b),
    .reinit_on_buffer_fault(bus.reinit_on_buffer_fault),
    .cal_pin_sel_alarm(bus.cal_pin_sel_alarm),
    .serializer_emphasis_level(bus.serializer_emphasis_level),
    .alarm_mask(bus.alarm_mask), .clear_valid(bus.clear_valid),
    .clear_flags(bus.clear_flags), .clear_lanes(bus.clear_lanes),
    .alarm_flags(bus.alarm_flags),
    .per_lane_buffer_fault_flags(bus.per_lane_buffer_fault_flags),
    .alarm_summary(bus.alarm_summary),
    .calibration_status_pin(bus.calibration_status_pin),
    .in_data_state(bus.in_data_state));
  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int period_of(input logic [4:0] p);
    return int'(p) + 1;
  endfunction
  function automatic logic swapped(input logic d, input logic s);
    return d & s;
  endfunction
  task automatic chk1(input logic a, input logic e);
    samples_checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic chkv(input logic [15:0] a, input logic [15:0] e);
    samples_checked++;
    if (a !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  // host sequences the enable itself, so just load and wait out busy
  task automatic cfg(input logic en, input logic s64, input logic sc1, input logic ri);
    i_cfg_load = 1;
    i_enable = en;
    i_use_64b66b = s64;
    i_subclass1 = sc1;
    i_reinit_on_fault = ri;
    tick(1);
    i_cfg_load = 0;
    t = 0;
    while (o_busy !== 1'b0 && t < 9) begin
      tick(1);
      t++;
    end
    tick(3);
  endtask
  task automatic clr(input logic [5:0] f, input logic [15:0] l);
    i_clear = 1;
    i_clear_flags = f;
    i_clear_lanes = l;
    tick(1);
    i_clear = 0;
    tick(1);
  endtask
  // bounded: a counter that never wraps must not hang the run
  task automatic edge_gap(output int m);
    m = 0;
    while (o_frame_counter_edge !== 1'b1 && m < 99) begin
      tick(1);
      m++;
    end
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************
  // clock, timeout, sequence
  // ****************
  initial begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  // whole sequence needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    {i_cfg_load, i_enable, i_use_64b66b, i_subclass1, i_reinit_on_fault, i_cal_pin_alarm,
      i_input_swap, i_clear, i_emphasis, i_period_m1, i_alarm_mask, i_clear_flags,
      i_clear_lanes, i_lane_overflow, i_lane_underflow, i_timing_ref, i_clk_a_phase,
      i_clk_b_phase, i_nco_upset, i_channel_a_power_down, i_channel_b_power_down,
      i_dual_channel} = '0;
    {i_sync_req_n, i_pll_locked, i_srst} = 3'h7;
    {n_mismatch, samples_checked, cyc} = '0;
    seed = 32'hae1a6cfe;
    repeat (12) @(posedge i_mclk);
    #1;
    i_srst = 0;
    i_period_m1 = 5'h14;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      {i_dual_channel, i_input_swap, i_emphasis} = seed[6:0];
      cfg(1'b1, 1'b1, 1'b0, 1'b0);
      chk1(o_link_reset, 1'b0);
      chk1(bus.in_data_state, 1'b1);
      chkv(16'(o_serializer_emphasis_level), 16'(i_emphasis));
      chk1(o_channel_a_from_input_b, swapped(i_dual_channel, i_input_swap));
      chk1(o_channel_b_from_input_a, swapped(i_dual_channel, i_input_swap));
      cfg(1'b0, 1'b1, 1'b0, 1'b0);
      chk1(o_serializer_power_down, 1'b1);
      chk1(o_link_clock_gate_en, 1'b0);
    end
    // lane faults, then a clear racing a new fault on the same lane
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      oh = 16'h0001 << seed[3:0];
      {i_lane_overflow, i_lane_underflow} = seed[4] ? {oh, 16'h0000} : {16'h0000, oh};
      tick(1);
      {i_lane_overflow, i_lane_underflow} = '0;
      tick(2);
      chkv(bus.per_lane_buffer_fault_flags, oh);
      chk1(o_alarm_flags[link_alarm_pkg::ALM_FIFO], 1'b1);
      i_clear = 1;
      i_clear_flags = 6'h01;
      i_clear_lanes = oh;
      tick(1);
      i_clear = 0;
      i_lane_overflow = oh;
      tick(1);
      i_lane_overflow = '0;
      tick(1);
      chkv(bus.per_lane_buffer_fault_flags, oh);
      chk1(o_alarm_flags[link_alarm_pkg::ALM_FIFO], 1'b1);
      clr(6'h01, oh);
      chkv(bus.per_lane_buffer_fault_flags, 16'h0000);
      chk1(o_alarm_flags[link_alarm_pkg::ALM_FIFO], 1'b0);
    end
    // masked then unmasked summary and pin
    i_alarm_mask = 6'h01;
    i_cal_pin_alarm = 1;
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    clr(6'h3f, 16'hffff);
    i_lane_overflow = 16'h0001;
    tick(1);
    i_lane_overflow = '0;
    tick(3);
    chk1(o_alarm, 1'b0);
    i_alarm_mask = 6'h3e;
    cfg(1'b0, 1'b1, 1'b0, 1'b0);
    chk1(o_alarm, 1'b1);
    chk1(bus.calibration_status_pin, 1'b1);
    // upsets from other domains
    cfg(1'b1, 1'b1, 1'b0, 1'b0);
    clr(6'h3f, 16'hffff);
    chk1(o_alarm_flags[link_alarm_pkg::ALM_CLK], 1'b0);
    i_nco_upset = 1;
    i_clk_a_phase = 1;
    tick(8);
    chk1(o_alarm_flags[link_alarm_pkg::ALM_NCO], 1'b1);
    chk1(o_alarm_flags[link_alarm_pkg::ALM_CLK], 1'b1);
    {i_nco_upset, i_clk_a_phase, i_pll_locked} = 3'h0;
    tick(6);
    chk1(o_alarm_flags[link_alarm_pkg::ALM_PLL], 1'b1);
    i_pll_locked = 1;
    // a powered-down channel keeps the clock compare quiet
    i_channel_a_power_down = 1;
    tick(3);
    clr(6'h20, 16'h0000);
    i_clk_b_phase = 1;
    tick(8);
    chk1(o_alarm_flags[link_alarm_pkg::ALM_CLK], 1'b0);
    {i_channel_a_power_down, i_clk_b_phase} = 2'h0;
    // free-running counter, then restart by the timing reference
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    edge_gap(n);
    tick(1);
    edge_gap(n);
    chkv(16'(n + 1), 16'(period_of(i_period_m1)));
    cfg(1'b1, 1'b0, 1'b1, 1'b0);
    clr(6'h08, 16'h0000);
    edge_gap(n);
    tick(3);
    i_timing_ref = 1;
    edge_gap(n);
    chk1(n < 7, 1'b1);
    tick(1);
    edge_gap(n);
    chkv(16'(n + 1), 16'(period_of(i_period_m1)));
    chk1(o_alarm_flags[link_alarm_pkg::ALM_REALIGN], 1'b1);
    i_timing_ref = 0;
    // receiver sync request in 8b/10b, subclass 0
    i_sync_req_n = 0;
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    chk1(o_start_sync, 1'b1);
    i_sync_req_n = 1;
    tick(3);
    chk1(o_start_align, 1'b1);
    for (n = 0; n < 60 && bus.in_data_state !== 1'b1; n++)
      tick(1);
    chk1(bus.in_data_state, 1'b1);
    i_sync_req_n = 0;
    tick(5);
    chk1(o_start_sync, 1'b1);
    i_sync_req_n = 1;
    // automatic reinit after a buffer fault
    cfg(1'b1, 1'b1, 1'b0, 1'b1);
    i_lane_overflow = 16'h0001;
    tick(1);
    i_lane_overflow = '0;
    n = 0;
    repeat (20) begin
      tick(1);
      if (o_link_reset === 1'b1)
        n++;
    end
    chkv(16'(n), 16'(link_alarm_pkg::REINIT_CYCLES));
    end_of_test();
  end
endmodule
`default_nettype wire
